// File: cosd_pkg.sv
// Package of register map, field positions and reset values for the shutdown/steer block
package cosd_pkg;
  // Register byte offsets (word aligned)
  localparam logic [3:0] COSD_SRC_EN_OFFSET = 4'h0;
  localparam logic [3:0] COSD_OVERRIDE_OFFSET = 4'h4;
  localparam logic [3:0] COSD_STEER_OFFSET = 4'h8;
  localparam logic [3:0] COSD_WAVE_CTRL_OFFSET = 4'hC;
  // Source-enable field positions
  localparam int COSD_PIN_EN_BIT = 0;
  localparam int COSD_CMP1_EN_BIT = 1;
  localparam int COSD_CMP2_EN_BIT = 2;
  localparam int COSD_CELL_EN_BIT = 3;
  // Shutdown status position in the source-enable register
  localparam int COSD_STATUS_BIT = 7;
  // Override register: ac code at [3:2], bd code at [5:4]
  localparam int COSD_OVR_AC_LSB = 2;
  localparam int COSD_OVR_BD_LSB = 4;
  // Steering register: steer enables at [3:0], static levels at [7:4]
  localparam int COSD_STATIC_LSB = 4;
  // Wave control: polarity at [3:0]
  localparam int COSD_OUTPUTS = 4;
  // Reset values
  localparam logic [3:0] COSD_SRC_EN_RESET = 4'h0;
  localparam logic [3:0] COSD_OVERRIDE_RESET = 4'h0;
  localparam logic [7:0] COSD_STEER_RESET = 8'h00;
  localparam logic [3:0] COSD_POL_RESET = 4'h0;
  // Override codes
  localparam logic [1:0] COSD_OVR_INACTIVE = 2'h0;
  localparam logic [1:0] COSD_OVR_TRISTATE = 2'h1;
  localparam logic [1:0] COSD_OVR_DRIVE0 = 2'h2;
  localparam logic [1:0] COSD_OVR_DRIVE1 = 2'h3;
  // AXI responses
  localparam logic [1:0] COSD_RESP_OKAY = 2'h0;
  localparam logic [1:0] COSD_RESP_SLVERR = 2'h2;
  // Bus slave states
  typedef enum logic [1:0] {COSD_IDLE, COSD_RESP} cosd_bus_state_type;
endpackage : cosd_pkg

// File: cosd_out_stage.sv
// Per-output steering, polarity and shutdown override stage
`timescale 1ns/10ps
`default_nettype none
module cosd_out_stage
  import cosd_pkg::*;
#(
  parameter int N = 4
) (
  input wire logic sys_clk,
  input wire logic rst_n,
  input wire logic [N-1:0] wave_in,
  input wire logic [N-1:0] polarity,
  input wire logic [N-1:0] steer_en,
  input wire logic [N-1:0] static_level,
  input wire logic shutdown,
  input wire logic [1:0] override_ac,
  input wire logic [1:0] override_bd,
  output logic [N-1:0] out_level,
  output logic [N-1:0] out_oe_n
);
  initial begin
    if (N != 4) $error("cosd_out_stage serves exactly four outputs");
  end

  logic [N-1:0] level_reg;
  logic [N-1:0] level_next;
  logic [N-1:0] oe_n_reg;
  logic [N-1:0] oe_n_next;

  //////////////////////////////////////////////////////////////////////////////
  // Next output per channel; A and C (0,2) share one code, B and D (1,3) the other
  genvar g;
  generate
    for (g = 0; g < N; g++) begin : g_ch
      logic [1:0] code;
      assign code = (g % 2 == 0) ? override_ac : override_bd;
      always_comb begin
        level_next[g] = steer_en[g] ? (wave_in[g] ^ polarity[g]) : static_level[g];
        oe_n_next[g] = 1'b0;
        if (shutdown) begin
          case (code)
            COSD_OVR_DRIVE1: level_next[g] = 1'b1;
            COSD_OVR_DRIVE0: level_next[g] = 1'b0;
            COSD_OVR_TRISTATE: begin
              // Level held low, so the switch model shows the released pin high
              level_next[g] = 1'b0;
              oe_n_next[g] = 1'b1;
            end
            default: level_next[g] = polarity[g]; // Inactive level is polarity itself
          endcase
        end
      end
    end
  endgenerate

  //////////////////////////////////////////////////////////////////////////////
  // Register outputs; after reset drive inactive low
  always_ff @(posedge sys_clk or negedge rst_n) begin
    if (!rst_n) begin
      level_reg <= '0;
      oe_n_reg <= '0;
    end else begin
      level_reg <= level_next;
      oe_n_reg <= oe_n_next;
    end
  end

  assign out_level = level_reg;
  assign out_oe_n = oe_n_reg;
endmodule : cosd_out_stage
`default_nettype wire

// File: cosd_top.sv
// Auto-shutdown source selection and output steering with AXI4-Lite registers
`timescale 1ns/10ps
`default_nettype none
// Functional notes
// - Comparator-1 low forces shutdown when enabled
// - Selected pin low forces shutdown when enabled
// - Disabled pin source never affects shutdown
// - Enables gate sources independently, OR-combined
// - Steer passes polarised waveform, else static level
// - Shutdown applies per-pair two-bit override code
module cosd_top
  import cosd_pkg::*;
#(
  parameter int ADDR_W = 4
) (
  input wire logic sys_clk,
  input wire logic rst_n,
  // AXI4-Lite slave
  input wire logic [ADDR_W-1:0] s_axi_awaddr,
  input wire logic s_axi_awvalid,
  output logic s_axi_awready,
  input wire logic [31:0] s_axi_wdata,
  input wire logic [3:0] s_axi_wstrb,
  input wire logic s_axi_wvalid,
  output logic s_axi_wready,
  output logic [1:0] s_axi_bresp,
  output logic s_axi_bvalid,
  input wire logic s_axi_bready,
  input wire logic [ADDR_W-1:0] s_axi_araddr,
  input wire logic s_axi_arvalid,
  output logic s_axi_arready,
  output logic [31:0] s_axi_rdata,
  output logic [1:0] s_axi_rresp,
  output logic s_axi_rvalid,
  input wire logic s_axi_rready,
  // Shutdown sources
  input wire logic shutdown_pin_select,
  input wire logic first_comparator_out,
  input wire logic second_comparator_out,
  input wire logic logic_cell_two_out,
  // Live waveforms A..D
  input wire logic [3:0] wave_in,
  // Outputs A..D
  output logic [3:0] out_level,
  output logic [3:0] out_oe_n,
  output logic shutdown_active
);
  initial begin
    if (ADDR_W < 4) $error("cosd_top needs at least four address bits");
  end

  //////////////////////////////////////////////////////////////////////////////
  // Register state
  logic [3:0] src_en_reg; // Source enables, bit per source
  logic [3:0] src_en_next;
  logic [3:0] override_reg; // {bd code, ac code}
  logic [3:0] override_next;
  logic [7:0] steer_reg; // {static levels, steer enables}
  logic [7:0] steer_next;
  logic [3:0] pol_reg; // Waveform polarity per output
  logic [3:0] pol_next;
  logic shutdown_reg; // Registered shutdown request
  logic shutdown_next;

  // Bus slave state
  cosd_bus_state_type wr_state_reg;
  cosd_bus_state_type wr_state_next;
  cosd_bus_state_type rd_state_reg;
  cosd_bus_state_type rd_state_next;
  logic aw_got_reg; // Write address captured
  logic aw_got_next;
  logic w_got_reg; // Write data captured
  logic w_got_next;
  logic [ADDR_W-1:0] awaddr_reg;
  logic [ADDR_W-1:0] awaddr_next;
  logic [31:0] wdata_reg;
  logic [31:0] wdata_next;
  logic wstrb0_reg; // Only byte lane 0 carries register bits
  logic wstrb0_next;
  logic [1:0] bresp_reg;
  logic [1:0] bresp_next;
  logic [31:0] rdata_reg;
  logic [31:0] rdata_next;
  logic [1:0] rresp_reg;
  logic [1:0] rresp_next;
  logic awready_reg; // Write address slot free
  logic wready_reg; // Write data slot free
  logic arready_reg; // Read address slot free
  logic bvalid_reg; // Write response standing
  logic rvalid_reg; // Read data standing

  //////////////////////////////////////////////////////////////////////////////
  // Shutdown request: each enabled source contributes its own active level
  logic [3:0] src_active;
  always_comb begin
    src_active[COSD_PIN_EN_BIT] = ~shutdown_pin_select;
    src_active[COSD_CMP1_EN_BIT] = ~first_comparator_out;
    src_active[COSD_CMP2_EN_BIT] = ~second_comparator_out;
    src_active[COSD_CELL_EN_BIT] = logic_cell_two_out;
    shutdown_next = |(src_active & src_en_reg);
  end

  //////////////////////////////////////////////////////////////////////////////
  // Write channel: address and data taken in either order, then response
  logic wr_fire;
  always_comb begin
    wr_state_next = wr_state_reg;
    aw_got_next = aw_got_reg;
    w_got_next = w_got_reg;
    awaddr_next = awaddr_reg;
    wdata_next = wdata_reg;
    wstrb0_next = wstrb0_reg;
    bresp_next = bresp_reg;
    wr_fire = 1'b0;
    src_en_next = src_en_reg;
    override_next = override_reg;
    steer_next = steer_reg;
    pol_next = pol_reg;
    case (wr_state_reg)
      COSD_IDLE: begin
        // Take only on a real handshake, or a held request lands twice
        if (awready_reg && s_axi_awvalid) begin
          aw_got_next = 1'b1;
          awaddr_next = s_axi_awaddr;
        end
        if (wready_reg && s_axi_wvalid) begin
          w_got_next = 1'b1;
          wdata_next = s_axi_wdata;
          wstrb0_next = s_axi_wstrb[0];
        end
        if (aw_got_reg && w_got_reg) begin
          wr_fire = 1'b1;
          aw_got_next = 1'b0;
          w_got_next = 1'b0;
          wr_state_next = COSD_RESP;
          bresp_next = COSD_RESP_OKAY;
          case (awaddr_reg[3:0])
            COSD_SRC_EN_OFFSET: begin
              if (wstrb0_reg) src_en_next = wdata_reg[3:0];
            end
            COSD_OVERRIDE_OFFSET: begin
              if (wstrb0_reg) override_next = wdata_reg[5:2];
            end
            COSD_STEER_OFFSET: begin
              if (wstrb0_reg) steer_next = wdata_reg[7:0];
            end
            COSD_WAVE_CTRL_OFFSET: begin
              if (wstrb0_reg) pol_next = wdata_reg[3:0];
            end
            default: bresp_next = COSD_RESP_SLVERR; // Unmapped address
          endcase
          if ((awaddr_reg >> 4) != '0) bresp_next = COSD_RESP_SLVERR; // Beyond the map
        end
      end
      COSD_RESP: begin
        if (s_axi_bready) wr_state_next = COSD_IDLE;
      end
      default: wr_state_next = COSD_IDLE;
    endcase
  end

  //////////////////////////////////////////////////////////////////////////////
  // Read channel: one-cycle address take, data registered, held until rready
  always_comb begin
    rd_state_next = rd_state_reg;
    rdata_next = rdata_reg;
    rresp_next = rresp_reg;
    case (rd_state_reg)
      COSD_IDLE: begin
        if (arready_reg && s_axi_arvalid) begin
          rd_state_next = COSD_RESP;
          rresp_next = COSD_RESP_OKAY;
          rdata_next = 32'h0000_0000;
          case (s_axi_araddr[3:0])
            COSD_SRC_EN_OFFSET: begin
              rdata_next[3:0] = src_en_reg;
              rdata_next[COSD_STATUS_BIT] = shutdown_reg; // Live shutdown status
            end
            COSD_OVERRIDE_OFFSET: rdata_next[5:2] = override_reg;
            COSD_STEER_OFFSET: rdata_next[7:0] = steer_reg;
            COSD_WAVE_CTRL_OFFSET: rdata_next[3:0] = pol_reg;
            default: rresp_next = COSD_RESP_SLVERR;
          endcase
          if ((s_axi_araddr >> 4) != '0) begin
            rresp_next = COSD_RESP_SLVERR;
            rdata_next = 32'h0000_0000;
          end
        end
      end
      COSD_RESP: begin
        if (s_axi_rready) rd_state_next = COSD_IDLE;
      end
      default: rd_state_next = COSD_IDLE;
    endcase
  end

  //////////////////////////////////////////////////////////////////////////////
  // Register all state; enables and controls clear at reset
  always_ff @(posedge sys_clk or negedge rst_n) begin
    if (!rst_n) begin
      src_en_reg <= COSD_SRC_EN_RESET;
      override_reg <= COSD_OVERRIDE_RESET;
      steer_reg <= COSD_STEER_RESET;
      pol_reg <= COSD_POL_RESET;
      shutdown_reg <= 1'b0;
      wr_state_reg <= COSD_IDLE;
      rd_state_reg <= COSD_IDLE;
      aw_got_reg <= 1'b0;
      w_got_reg <= 1'b0;
      awaddr_reg <= '0;
      wdata_reg <= 32'h0000_0000;
      wstrb0_reg <= 1'b0;
      bresp_reg <= COSD_RESP_OKAY;
      rdata_reg <= 32'h0000_0000;
      rresp_reg <= COSD_RESP_OKAY;
    end else begin
      src_en_reg <= src_en_next;
      override_reg <= override_next;
      steer_reg <= steer_next;
      pol_reg <= pol_next;
      shutdown_reg <= shutdown_next;
      wr_state_reg <= wr_state_next;
      rd_state_reg <= rd_state_next;
      aw_got_reg <= aw_got_next;
      w_got_reg <= w_got_next;
      awaddr_reg <= awaddr_next;
      wdata_reg <= wdata_next;
      wstrb0_reg <= wstrb0_next;
      bresp_reg <= bresp_next;
      rdata_reg <= rdata_next;
      rresp_reg <= rresp_next;
    end
  end

  // Handshake flags straight from flops; each follows the next state
  always_ff @(posedge sys_clk or negedge rst_n) begin
    if (!rst_n) begin
      awready_reg <= 1'b0;
      wready_reg <= 1'b0;
      arready_reg <= 1'b0;
      bvalid_reg <= 1'b0;
      rvalid_reg <= 1'b0;
    end else begin
      awready_reg <= (wr_state_next == COSD_IDLE) && !aw_got_next && !wr_fire;
      wready_reg <= (wr_state_next == COSD_IDLE) && !w_got_next && !wr_fire;
      arready_reg <= (rd_state_next == COSD_IDLE);
      bvalid_reg <= (wr_state_next == COSD_RESP);
      rvalid_reg <= (rd_state_next == COSD_RESP);
    end
  end

  //////////////////////////////////////////////////////////////////////////////
  // Output stage: steering, polarity and override, registered inside
  cosd_out_stage #(.N(COSD_OUTPUTS)) u_out (
    .sys_clk(sys_clk),
    .rst_n(rst_n),
    .wave_in(wave_in),
    .polarity(pol_reg),
    .steer_en(steer_reg[3:0]),
    .static_level(steer_reg[7:COSD_STATIC_LSB]),
    .shutdown(shutdown_reg),
    .override_ac(override_reg[1:0]),
    .override_bd(override_reg[3:2]),
    .out_level(out_level),
    .out_oe_n(out_oe_n)
  );

  assign s_axi_awready = awready_reg;
  assign s_axi_wready = wready_reg;
  assign s_axi_bvalid = bvalid_reg;
  assign s_axi_bresp = bresp_reg;
  assign s_axi_arready = arready_reg;
  assign s_axi_rvalid = rvalid_reg;
  assign s_axi_rdata = rdata_reg;
  assign s_axi_rresp = rresp_reg;
  assign shutdown_active = shutdown_reg;
endmodule : cosd_top
`default_nettype wire

// File: cosd_monitor.sv
// Checker of shutdown source gating and output override at the top ports
`timescale 1ns/10ps
`default_nettype none
module cosd_monitor
  import cosd_pkg::*;
#(
  parameter int ADDR_W = 4
) (
  input wire logic sys_clk,
  input wire logic rst_n,
  input wire logic [ADDR_W-1:0] s_axi_awaddr,
  input wire logic s_axi_awvalid,
  input wire logic s_axi_awready,
  input wire logic [31:0] s_axi_wdata,
  input wire logic [3:0] s_axi_wstrb,
  input wire logic s_axi_wvalid,
  input wire logic s_axi_wready,
  input wire logic shutdown_pin_select,
  input wire logic first_comparator_out,
  input wire logic second_comparator_out,
  input wire logic logic_cell_two_out,
  input wire logic [3:0] out_level,
  input wire logic [3:0] out_oe_n,
  input wire logic shutdown_active
);
  logic [ADDR_W-1:0] a_q;
  logic [7:0] d_q;
  logic ha, hw, s_q;
  logic [3:0] en_reg, ovr_reg, act;
  // Active state of each source, in enable bit order
  assign act = {logic_cell_two_out, ~second_comparator_out, ~first_comparator_out,
    ~shutdown_pin_select};
  // Shadow fields commit one edge after capture, as the slave does
  always_ff @(posedge sys_clk or negedge rst_n) begin
    if (!rst_n) begin
      {ha, hw, en_reg, ovr_reg} <= '0;
    end else begin
      if (s_axi_awvalid && s_axi_awready) begin
        ha <= 1'b1;
        a_q <= s_axi_awaddr;
      end
      if (s_axi_wvalid && s_axi_wready) begin
        hw <= 1'b1;
        {s_q, d_q} <= {s_axi_wstrb[0], s_axi_wdata[7:0]};
      end
      if (ha && hw) begin
        {ha, hw} <= 2'h0;
        if (s_q && a_q == COSD_SRC_EN_OFFSET) en_reg <= d_q[3:0];
        if (s_q && a_q == COSD_OVERRIDE_OFFSET) ovr_reg <= d_q[5:2];
      end
    end
  end
  ////////////////////////////////////////////////////////////////////////////
  default clocking cb @(posedge sys_clk); endclocking
  default disable iff (!rst_n);
  property p_cmp1; en_reg[1] && !first_comparator_out |=> shutdown_active; endproperty
  a_cmp1: assert property (p_cmp1) else $error("comparator one ignored");
  property p_pin; en_reg[0] && !shutdown_pin_select |=> shutdown_active; endproperty
  a_pin: assert property (p_pin) else $error("pin source ignored");
  property p_pin_off;
    !en_reg[0] && !(|(en_reg[3:1] & act[3:1])) |=> !shutdown_active;
  endproperty
  a_pin_off: assert property (p_pin_off) else $error("disabled pin shut down");
  property p_or; 1'b1 |=> shutdown_active == $past(|(en_reg & act)); endproperty
  a_or: assert property (p_or) else $error("shutdown not OR of sources");
  property p_cell;
    (en_reg[3] && logic_cell_two_out) || (en_reg[2] && !second_comparator_out)
      |=> shutdown_active;
  endproperty
  a_cell: assert property (p_cell) else $error("cell or comparator two ignored");
  property p_steer; !shutdown_active |=> out_oe_n == 4'h0; endproperty
  a_steer: assert property (p_steer) else $error("output released outside shutdown");
  property p_tri;
    shutdown_active && ovr_reg[1:0] == COSD_OVR_TRISTATE |=> out_oe_n[0] && out_oe_n[2];
  endproperty
  a_tri: assert property (p_tri) else $error("pair A C not released");
  property p_drive;
    shutdown_active && ovr_reg[3:2] == COSD_OVR_DRIVE1
      |=> out_level[1] && out_level[3] && !out_oe_n[1] && !out_oe_n[3];
  endproperty
  a_drive: assert property (p_drive) else $error("pair B D not driven high");
endmodule : cosd_monitor
bind cosd_top cosd_monitor #(.ADDR_W(ADDR_W)) u_mon (.sys_clk(sys_clk), .rst_n(rst_n),
  .s_axi_awaddr(s_axi_awaddr), .s_axi_awvalid(s_axi_awvalid), .s_axi_awready(s_axi_awready),
  .s_axi_wdata(s_axi_wdata), .s_axi_wstrb(s_axi_wstrb), .s_axi_wvalid(s_axi_wvalid),
  .s_axi_wready(s_axi_wready), .shutdown_pin_select(shutdown_pin_select),
  .first_comparator_out(first_comparator_out), .second_comparator_out(second_comparator_out),
  .logic_cell_two_out(logic_cell_two_out), .out_level(out_level), .out_oe_n(out_oe_n),
  .shutdown_active(shutdown_active));
`default_nettype wire

// File: cosd_switch_model.sv
// Model of the power switch drivers fed by the four outputs
`timescale 1ns/10ps
`default_nettype none
module cosd_switch_model (
  input wire logic sys_clk,
  input wire logic [3:0] out_level,
  input wire logic [3:0] out_oe_n,
  output logic [3:0] pin
);
  logic [3:0] float_reg;
  // No keeper on a released gate, so it shows the inverse of the last level
  always_ff @(posedge sys_clk) float_reg <= ~out_level;
  assign pin = (out_level & ~out_oe_n) | (float_reg & out_oe_n);
endmodule : cosd_switch_model
`default_nettype wire

// File: tb_complementary_output_shutdown_steer.sv
// Self-checking bench: register access, shutdown sources, steering and override
`timescale 1ns/10ps
`default_nettype none
module tb_complementary_output_shutdown_steer;
  import cosd_pkg::*;
  logic sys_clk, rst_n, s_axi_awvalid, s_axi_awready, s_axi_wvalid, s_axi_wready;
  logic s_axi_bvalid, s_axi_bready, s_axi_arvalid, s_axi_arready, s_axi_rvalid;
  logic s_axi_rready, shutdown_active, shutdown_pin_select, first_comparator_out;
  logic second_comparator_out, logic_cell_two_out;
  logic [3:0] s_axi_awaddr, s_axi_araddr, s_axi_wstrb, wave_in, out_level, out_oe_n, pin;
  logic [31:0] s_axi_wdata, s_axi_rdata, seed, d;
  logic [1:0] s_axi_bresp, s_axi_rresp;
  int mismatches, checks_done, en, ovr, steer, pol;
  cosd_top dut (.*);
  cosd_switch_model u_sw (.*);
  ////////////////////////////////////////////////////////////////////////////
  task automatic check(input logic [31:0] got, input logic [31:0] exp);
    checks_done++;
    if (got !== exp) begin
      mismatches++;
      $display("BAD %0t got %h want %h", $time, got, exp);
    end
  endtask : check
  task automatic results;
    $display("mismatches %0d checks %0d", mismatches, checks_done);
    if (mismatches == 0 && checks_done > 0) $display("ALL TESTS PASSED");
    else $display("TESTS FAILED");
    $finish;
  endtask : results
  function automatic logic [31:0] xs();
    seed ^= seed << 13;
    seed ^= seed >> 17;
    seed ^= seed << 5;
    return seed;
  endfunction : xs
  // Both channels offered together, each released once taken
  task automatic wr(input logic [3:0] a, input logic [31:0] v, input logic [1:0] er);
    int n;
    n = 0;
    @(posedge sys_clk);
    s_axi_awaddr <= a;
    s_axi_wdata <= v;
    {s_axi_awvalid, s_axi_wvalid, s_axi_bready} <= 3'b111;
    do begin
      @(posedge sys_clk);
      if (s_axi_awready) s_axi_awvalid <= 1'b0;
      if (s_axi_wready) s_axi_wvalid <= 1'b0;
      n++;
    end while (!s_axi_bvalid && n < 50);
    s_axi_bready <= 1'b0;
    check({s_axi_bvalid, s_axi_bresp}, {1'b1, er});
  endtask : wr
  task automatic rd(input logic [3:0] a, input logic [1:0] er);
    int n;
    n = 0;
    @(posedge sys_clk);
    s_axi_araddr <= a;
    {s_axi_arvalid, s_axi_rready} <= 2'b11;
    do begin
      @(posedge sys_clk);
      if (s_axi_arready) s_axi_arvalid <= 1'b0;
      n++;
    end while (!s_axi_rvalid && n < 50);
    s_axi_rready <= 1'b0;
    d = s_axi_rdata;
    check({s_axi_rvalid, s_axi_rresp}, {1'b1, er});
  endtask : rd
  // Random sources and waveforms, then the model's view after the fixed lag
  task automatic drive;
    logic [31:0] v;
    logic [3:0] el, eo, act;
    logic sd;
    int c;
    v = xs();
    @(posedge sys_clk);
    {logic_cell_two_out, second_comparator_out, first_comparator_out} <= v[3:1];
    {shutdown_pin_select, wave_in} <= {v[0], v[7:4]};
    repeat (4) @(posedge sys_clk);
    act = {v[3], ~v[2], ~v[1], ~v[0]};
    sd = |(en[3:0] & act);
    check(shutdown_active, sd);
    for (int j = 0; j < 4; j++) begin
      c = (j % 2) ? ovr[3:2] : ovr[1:0];
      el[j] = sd ? (c == 3 || (c == 0 && pol[j])) : (steer[j] ? v[4 + j] ^ pol[j] : steer[j + 4]);
      eo[j] = sd && c == 1;
    end
    check(out_oe_n, eo);
    check(pin & ~eo, el & ~eo);
  endtask : drive
  ////////////////////////////////////////////////////////////////////////////
  initial begin
    sys_clk = 1'b0;
    forever #2 sys_clk = ~sys_clk;
  end
  // About 715 cycles are needed; some sixteen times that means a hang
  initial begin
    #48000;
    mismatches++;
    results();
  end
  initial begin
    {rst_n, s_axi_awvalid, s_axi_wvalid, s_axi_bready, s_axi_arvalid, s_axi_rready} = '0;
    {s_axi_awaddr, s_axi_araddr, s_axi_wdata, wave_in, logic_cell_two_out} = '0;
    {shutdown_pin_select, first_comparator_out, second_comparator_out} = 3'h7;
    {s_axi_wstrb, seed, en, ovr, steer, pol} = {4'hF, 32'd57, 128'h0};
    repeat (8) @(posedge sys_clk);
    rst_n <= 1'b1;
    for (int a = 0; a < 4; a++) begin
      rd(4'(a * 4), COSD_RESP_OKAY);
      check(d, 32'h0);
    end
    rd(4'h2, COSD_RESP_SLVERR);
    wr(4'h6, 32'hF, COSD_RESP_SLVERR);
    for (int i = 0; i < 6; i++) begin
      en = (i < 4) ? (1 << i) : ((i == 4) ? 0 : 15);
      wr(COSD_SRC_EN_OFFSET, en, COSD_RESP_OKAY);
      repeat (6) drive();
    end
    en = 1;
    wr(COSD_SRC_EN_OFFSET, en, COSD_RESP_OKAY);
    for (int k = 0; k < 16; k++) begin
      {ovr, pol, steer} = {k, int'(xs() & 15), int'(xs() & 255)};
      wr(COSD_WAVE_CTRL_OFFSET, pol, COSD_RESP_OKAY);
      wr(COSD_STEER_OFFSET, steer, COSD_RESP_OKAY);
      wr(COSD_OVERRIDE_OFFSET, ovr << 2, COSD_RESP_OKAY);
      rd(COSD_STEER_OFFSET, COSD_RESP_OKAY);
      check(d, steer);
      repeat (3) drive();
    end
    results();
  end
endmodule : tb_complementary_output_shutdown_steer
`default_nettype wire
